// ===== design/embedded_flash_controller.sv
`timescale 1ns/10ps
// What this block does
// - Programming only clears bits; ones come back only through erase.
// - Array is 128 pages of 8 rows of 64 words, 65536 words.
// - Word index: page in bits 15:9, row in 8:6, word in 5:0.
// - Single word reads go straight over the bus like RAM.
// - Verify pass compares every word with data; pass flag only if all match.
// - Verify pass builds a 32-bit signature, seed all ones, fixed polynomial.
// - Accepted command raises started flag, completion raises finished flag.
// - Started and finished flags clear by writing one to status bits.
// - Page erase leaves every bit of that page at one.
// - Code 0x22 erases whole array to ones, same handshake.
// - Code 0x33 programs one word at address with first data word.
// - Code 0xCC programs four data words at consecutive addresses.
// - Burst skips all-ones data words without a program cycle.
// - Code 0x44 programs every word with the first data word.
// - Locked and halted: array reads give zero; debugger reads get error.
// - While locked, debug access to on-chip RAM is blocked.
// - Non-erased 64-bit value in last two words arms the lock.
// - Command written while busy sets the busy-error flag.
// - Undefined command code written while idle sets the unknown-command flag.
module embedded_flash_controller
  import flash_ctrl_pkg::*;
#(
  parameter logic [TIMER_W-1:0] ERASE_CYCLES = TIMER_W'(ERASE_CYCLES_DFLT),
  parameter logic [TIMER_W-1:0] PROG_CYCLES = TIMER_W'(PROG_CYCLES_DFLT),
  parameter logic [TIMER_W-1:0] STEP_CYCLES = TIMER_W'(STEP_CYCLES_DFLT)
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic CPU_HALTED,
  input wire logic DEBUG_ACCESS,
  output logic RAM_DEBUG_BLOCK
);
  flash_port_if port ();

  // Bus data phase state
  logic dp_reg_wr_reg;
  logic [7:0] dp_off_reg;
  logic [WORD_AW-1:0] dp_word_reg;
  logic rd_wait_reg;
  logic rd_issued_reg;
  logic rd_zero_reg;
  logic err_first_reg;
  logic err_second_reg;
  logic [31:0] hrdata_reg;
  logic ram_block_reg;

  // Software-visible registers
  logic [31:0] command_reg;
  logic [31:0] config_reg;
  logic [FLAG_W-1:0] raw_reg;
  logic [FLAG_W-1:0] raw_next;
  logic [FLAG_W-1:0] mask_reg;
  logic [WORD_AW-1:0] address_reg;
  logic [31:0] data_reg [4];

  // Sequencer state
  seq_state_t state_reg;
  logic [31:0] op_code_reg;
  logic [WORD_AW-1:0] op_addr_reg;
  logic [31:0] op_data_reg [4];
  logic [16:0] walk_cnt_reg;
  logic [16:0] walk_len_reg;
  logic [2:0] prog_cnt_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic sig_valid_reg;

  logic addr_phase;
  logic reg_wr;
  logic cmd_wr;
  logic cmd_legal;
  logic busy;
  logic start;
  logic locked;
  logic bus_issue;
  logic seq_en;
  op_kind_t seq_kind;
  logic [WORD_AW-1:0] seq_addr;
  logic [31:0] seq_wdata;
  logic [2:0] prog_total;
  logic last_step;
  logic [31:0] signature;
  logic all_match;
  logic [31:0] reg_rdata;
  logic [FLAG_W-1:0] flag_set;
  logic [FLAG_W-1:0] flag_clr;

  assign addr_phase = HSEL && HTRANS[1] && HREADY;
  assign reg_wr = dp_reg_wr_reg;
  assign cmd_wr = reg_wr && dp_off_reg == OFF_COMMAND;
  assign busy = state_reg != S_IDLE;
  assign locked = port.lock;
  assign cmd_legal = HWDATA == CMD_PAGE_ERASE || HWDATA == CMD_MASS_ERASE || HWDATA == CMD_WRITE ||
                     HWDATA == CMD_MASS_WRITE || HWDATA == CMD_MASS_READ || HWDATA == CMD_BURST;
  assign start = cmd_wr && !busy && cmd_legal;

  // Address phase capture; register reads are fetched here for a zero-wait data phase
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dp_reg_wr_reg <= 1'b0;
      dp_off_reg <= 8'h00;
      dp_word_reg <= 16'h0000;
      hrdata_reg <= 32'h00000000;
    end else if (addr_phase) begin
      dp_reg_wr_reg <= HADDR[REG_SPACE_BIT] && HWRITE;
      dp_off_reg <= HADDR[7:0];
      dp_word_reg <= HADDR[WORD_AW+1:2];
      if (HADDR[REG_SPACE_BIT] && !HWRITE) begin
        hrdata_reg <= reg_rdata;
      end
    end else begin
      dp_reg_wr_reg <= 1'b0;
      if (rd_issued_reg) begin
        hrdata_reg <= rd_zero_reg ? 32'h00000000 : port.rdata;
      end
    end
  end

  // Array reads wait for the sequencer; locked debugger reads while halted get a two-cycle error
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_wait_reg <= 1'b0;
      rd_issued_reg <= 1'b0;
      rd_zero_reg <= 1'b0;
      err_first_reg <= 1'b0;
      err_second_reg <= 1'b0;
    end else begin
      err_second_reg <= err_first_reg;
      err_first_reg <= 1'b0;
      rd_issued_reg <= bus_issue;
      if (rd_issued_reg) begin
        rd_wait_reg <= 1'b0;
      end
      if (addr_phase && !HADDR[REG_SPACE_BIT] && !HWRITE) begin
        if (locked && CPU_HALTED && DEBUG_ACCESS) begin
          err_first_reg <= 1'b1;
        end else begin
          rd_wait_reg <= 1'b1;
          rd_zero_reg <= locked && CPU_HALTED;
        end
      end
    end
  end

  assign bus_issue = rd_wait_reg && !rd_issued_reg && !busy;
  assign HREADYOUT = !rd_wait_reg && !err_first_reg;
  assign HRESP = err_first_reg || err_second_reg;
  assign HRDATA = hrdata_reg;

  // Debug access to RAM is refused while the lock is armed
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ram_block_reg <= 1'b0;
    end else begin
      ram_block_reg <= locked;
    end
  end
  assign RAM_DEBUG_BLOCK = ram_block_reg;

  // Register read decode; reserved bits and holes read zero
  always_comb begin
    reg_rdata = 32'h00000000;
    case (HADDR[7:0])
      OFF_COMMAND: reg_rdata = command_reg;
      OFF_CONFIG: reg_rdata = config_reg;
      OFF_STATUS: reg_rdata = {26'h0000000, raw_reg & mask_reg};
      OFF_MASK: reg_rdata = {26'h0000000, mask_reg};
      OFF_RAW: reg_rdata = {26'h0000000, raw_reg};
      OFF_SIZE: reg_rdata = SIZE_VALUE;
      OFF_ADDRESS: reg_rdata = {16'h0000, address_reg};
      OFF_SIGNATURE: reg_rdata = signature;
      OFF_PROGRAM_DATA_WORD_FIRST: reg_rdata = data_reg[0];
      OFF_DATA1: reg_rdata = data_reg[1];
      OFF_DATA2: reg_rdata = data_reg[2];
      OFF_DATA3: reg_rdata = data_reg[3];
      default: reg_rdata = 32'h00000000;
    endcase
  end

  // Plain configuration registers; a rejected command touches none of them
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      command_reg <= COMMAND_RST;
      config_reg <= CONFIG_RST;
      mask_reg <= MASK_RST;
      address_reg <= ADDRESS_RST;
    end else begin
      if (start) begin
        command_reg <= HWDATA;
      end
      if (reg_wr && dp_off_reg == OFF_CONFIG) begin
        config_reg <= HWDATA;
      end
      if (reg_wr && dp_off_reg == OFF_MASK) begin
        mask_reg <= HWDATA[FLAG_W-1:0];
      end
      if (reg_wr && dp_off_reg == OFF_ADDRESS) begin
        address_reg <= HWDATA[WORD_AW-1:0];
      end
    end
  end

  // Data words, one per generate entry
  for (genvar i = 0; i < 4; i++) begin : g_data
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        data_reg[i] <= DATA_RST;
      end else if (reg_wr && dp_off_reg == OFF_PROGRAM_DATA_WORD_FIRST + 8'(4 * i)) begin
        data_reg[i] <= HWDATA;
      end
    end
  end

  // Status events; a set in the same cycle as its clear wins
  always_comb begin
    flag_set = '0;
    flag_set[FLAG_START] = start;
    flag_set[FLAG_DONE] = state_reg == S_DONE;
    flag_set[FLAG_PASS] = state_reg == S_DONE && op_code_reg == CMD_MASS_READ && all_match;
    flag_set[FLAG_BUSYERR] = cmd_wr && busy;
    flag_set[FLAG_ILLEGAL] = cmd_wr && !busy && !cmd_legal;
    flag_clr = '0;
    if (reg_wr && (dp_off_reg == OFF_STATUS || dp_off_reg == OFF_RAW)) begin
      flag_clr = HWDATA[FLAG_W-1:0];
    end
    raw_next = (raw_reg & ~flag_clr) | flag_set;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      raw_reg <= '0;
    end else begin
      raw_reg <= raw_next;
    end
  end

  // Walk step: what the sequencer drives into the array this cycle
  always_comb begin
    seq_kind = OP_PROG;
    seq_addr = op_addr_reg;
    seq_wdata = op_data_reg[0];
    seq_en = state_reg == S_WALK;
    case (op_code_reg)
      CMD_PAGE_ERASE: begin
        seq_kind = OP_ERASE;
        seq_addr = {op_addr_reg[PAGE_MSB:PAGE_LSB], walk_cnt_reg[PAGE_LSB-1:0]};
      end
      CMD_MASS_ERASE: begin
        seq_kind = OP_ERASE;
        seq_addr = walk_cnt_reg[WORD_AW-1:0];
      end
      CMD_MASS_WRITE: begin
        seq_addr = walk_cnt_reg[WORD_AW-1:0];
      end
      CMD_MASS_READ: begin
        seq_kind = OP_READ;
        seq_addr = walk_cnt_reg[WORD_AW-1:0];
      end
      CMD_BURST: begin
        seq_addr = op_addr_reg + walk_cnt_reg[WORD_AW-1:0];
        seq_wdata = op_data_reg[walk_cnt_reg[1:0]];
        seq_en = state_reg == S_WALK && seq_wdata != ERASED_WORD;
      end
      default: ;
    endcase
  end

  assign last_step = walk_cnt_reg == walk_len_reg - ONE_WORD;
  assign prog_total = prog_cnt_reg + {2'b00, seq_en};

  // Array port: sequencer owns it while busy, bus reads otherwise
  assign port.op_en = seq_en || bus_issue;
  assign port.op_kind = busy ? seq_kind : OP_READ;
  assign port.addr = busy ? seq_addr : dp_word_reg;
  assign port.wdata = seq_wdata;

  // Sequencer: operands are latched at start so later writes cannot corrupt them
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= S_IDLE;
      op_code_reg <= COMMAND_RST;
      op_addr_reg <= ADDRESS_RST;
      walk_cnt_reg <= 17'h00000;
      walk_len_reg <= ONE_WORD;
      prog_cnt_reg <= 3'h0;
      timer_reg <= DRAIN_CYCLES;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            state_reg <= S_WALK;
            op_code_reg <= HWDATA;
            op_addr_reg <= address_reg;
            walk_cnt_reg <= 17'h00000;
            prog_cnt_reg <= 3'h0;
            case (HWDATA)
              CMD_PAGE_ERASE: walk_len_reg <= PAGE_WORDS;
              CMD_WRITE: walk_len_reg <= ONE_WORD;
              CMD_BURST: walk_len_reg <= BURST_WORDS;
              default: walk_len_reg <= ARRAY_WORDS;
            endcase
          end
        end
        S_WALK: begin
          walk_cnt_reg <= walk_cnt_reg + ONE_WORD;
          prog_cnt_reg <= prog_total;
          if (last_step) begin
            state_reg <= S_WAIT;
            case (op_code_reg)
              CMD_PAGE_ERASE, CMD_MASS_ERASE: timer_reg <= ERASE_CYCLES;
              CMD_MASS_READ: timer_reg <= DRAIN_CYCLES;
              CMD_BURST: begin
                // Each extra burst word adds one step; skipped words add nothing
                if (prog_total == 3'h0) begin
                  timer_reg <= DRAIN_CYCLES;
                end else begin
                  timer_reg <= PROG_CYCLES + TIMER_W'(STEP_CYCLES * (prog_total - 3'h1));
                end
              end
              default: timer_reg <= PROG_CYCLES;
            endcase
          end
        end
        S_WAIT: begin
          timer_reg <= timer_reg - DRAIN_CYCLES;
          if (timer_reg == DRAIN_CYCLES) begin
            state_reg <= S_DONE;
          end
        end
        S_DONE: state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Latch data words with the command
  for (genvar j = 0; j < 4; j++) begin : g_opdata
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        op_data_reg[j] <= DATA_RST;
      end else if (start) begin
        op_data_reg[j] <= data_reg[j];
      end
    end
  end

  // Array read data arrives one cycle after the walk issues it
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sig_valid_reg <= 1'b0;
    end else begin
      sig_valid_reg <= busy && seq_en && seq_kind == OP_READ;
    end
  end

  flash_array u_array (
    .clk(CLK),
    .port(port.array)
  );

  signature_unit u_sig (
    .clk(CLK),
    .rst_n(RST_N),
    .clear(start && HWDATA == CMD_MASS_READ),
    .valid(sig_valid_reg),
    .data(port.rdata),
    .pattern(op_data_reg[0]),
    .signature(signature),
    .all_match(all_match)
  );
endmodule

// ===== design/flash_array.sv
`timescale 1ns/10ps
module flash_array
  import flash_ctrl_pkg::*;
(
  input wire logic clk,
  flash_port_if.array port
);
  logic [31:0] mem [WORDS];
  logic [31:0] rdata_reg;

  // Programming can only clear bits; erase returns a word to ones
  always_ff @(posedge clk) begin
    if (port.op_en) begin
      case (port.op_kind)
        OP_PROG: mem[port.addr] <= mem[port.addr] & port.wdata;
        OP_ERASE: mem[port.addr] <= ERASED_WORD;
        default: ;
      endcase
    end
  end

  // Registered read port, one cycle latency
  always_ff @(posedge clk) begin
    if (port.op_en && port.op_kind == OP_READ) begin
      rdata_reg <= mem[port.addr];
    end
  end

  assign port.rdata = rdata_reg;
  // Any non-erased value in the last two words arms the lock
  assign port.lock = ~&{mem[LOCK_HI_WORD], mem[LOCK_LO_WORD]};
endmodule

// ===== design/flash_ctrl_pkg.sv
package flash_ctrl_pkg;

  // Array geometry
  localparam int WORD_AW = 16;
  localparam int WORDS = 65536;
  localparam int PAGE_MSB = 15;
  localparam int PAGE_LSB = 9;
  localparam int ROW_LSB = 6;
  localparam logic [16:0] PAGE_WORDS = 17'h00200;
  localparam logic [16:0] ARRAY_WORDS = 17'h10000;
  localparam logic [16:0] ONE_WORD = 17'h00001;
  localparam logic [16:0] BURST_WORDS = 17'h00004;
  localparam logic [15:0] LOCK_HI_WORD = 16'hffff;
  localparam logic [15:0] LOCK_LO_WORD = 16'hfffe;
  localparam logic [31:0] ERASED_WORD = 32'hffffffff;

  // Bus map: bit 18 of the byte address splits array window from registers
  localparam int REG_SPACE_BIT = 18;
  localparam logic [7:0] OFF_COMMAND = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0c;
  localparam logic [7:0] OFF_RAW = 8'h10;
  localparam logic [7:0] OFF_SIZE = 8'h14;
  localparam logic [7:0] OFF_ADDRESS = 8'h18;
  localparam logic [7:0] OFF_SIGNATURE = 8'h24;
  localparam logic [7:0] OFF_PROGRAM_DATA_WORD_FIRST = 8'h40;
  localparam logic [7:0] OFF_DATA1 = 8'h44;
  localparam logic [7:0] OFF_DATA2 = 8'h48;
  localparam logic [7:0] OFF_DATA3 = 8'h4c;

  // Reset values and fixed read values
  localparam logic [31:0] COMMAND_RST = 32'h00000000;
  localparam logic [31:0] CONFIG_RST = 32'h00000000;
  localparam logic [5:0] MASK_RST = 6'h3f;
  localparam logic [15:0] ADDRESS_RST = 16'h0000;
  localparam logic [31:0] DATA_RST = 32'hffffffff;
  localparam logic [31:0] SIZE_VALUE = 32'h0003fffc;

  // Status flag positions
  localparam int FLAG_DONE = 0;
  localparam int FLAG_START = 1;
  localparam int FLAG_BUSYERR = 2;
  localparam int FLAG_ILLEGAL = 3;
  localparam int FLAG_PASS = 4;
  localparam int FLAG_W = 6;

  // Command codes
  localparam logic [31:0] CMD_PAGE_ERASE = 32'h00000011;
  localparam logic [31:0] CMD_MASS_ERASE = 32'h00000022;
  localparam logic [31:0] CMD_WRITE = 32'h00000033;
  localparam logic [31:0] CMD_MASS_WRITE = 32'h00000044;
  localparam logic [31:0] CMD_MASS_READ = 32'h00000055;
  localparam logic [31:0] CMD_BURST = 32'h000000cc;

  // Signature polynomial x32+x31+x4+x3+x1+1 and seed
  localparam logic [31:0] SIG_POLY = 32'h8000001b;
  localparam logic [31:0] SIG_SEED = 32'hffffffff;

  // Timing: clock in MHz, times in microseconds as printed
  localparam int CLK_MHZ = 250;
  localparam real ERASE_TIME_US = 21500.0;
  localparam int PROG_TIME_US = 44;
  localparam int BURST_STEP_US = 21;
  localparam int TIMER_W = 24;
  localparam int ERASE_CYCLES_DFLT = int'(ERASE_TIME_US) * CLK_MHZ;
  localparam int PROG_CYCLES_DFLT = PROG_TIME_US * CLK_MHZ;
  localparam int STEP_CYCLES_DFLT = BURST_STEP_US * CLK_MHZ;
  localparam logic [TIMER_W-1:0] DRAIN_CYCLES = 24'h000001;

  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_PROG = 2'b01,
    OP_ERASE = 2'b10
  } op_kind_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_WALK = 4'b0010,
    S_WAIT = 4'b0100,
    S_DONE = 4'b1000
  } seq_state_t;

endpackage

// ===== design/flash_port_if.sv
`timescale 1ns/10ps
interface flash_port_if;
  import flash_ctrl_pkg::*;
  logic op_en;
  op_kind_t op_kind;
  logic [WORD_AW-1:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic lock;
  modport ctrl (output op_en, output op_kind, output addr, output wdata, input rdata, input lock);
  modport array (input op_en, input op_kind, input addr, input wdata, output rdata, output lock);
endinterface

// ===== design/signature_unit.sv
`timescale 1ns/10ps
module signature_unit
  import flash_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic valid,
  input wire logic [31:0] data,
  input wire logic [31:0] pattern,
  output logic [31:0] signature,
  output logic all_match
);
  logic [31:0] sig_reg;
  logic [31:0] sig_next;
  logic match_reg;

  // Shift with feedback, then fold the data word in
  always_comb begin
    sig_next = {sig_reg[30:0], 1'b0} ^ (sig_reg[31] ? SIG_POLY : 32'h00000000) ^ data;
  end

  // Signature restarts from the seed at every verify pass
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sig_reg <= SIG_SEED;
    end else if (clear) begin
      sig_reg <= SIG_SEED;
    end else if (valid) begin
      sig_reg <= sig_next;
    end
  end

  // One mismatching word spoils the whole pass
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      match_reg <= 1'b0;
    end else if (clear) begin
      match_reg <= 1'b1;
    end else if (valid && data != pattern) begin
      match_reg <= 1'b0;
    end
  end

  assign signature = sig_reg;
  assign all_match = match_reg;
endmodule

// ===== test/ahb_master.sv
`timescale 1ns/10ps
// Single word AHB-Lite master standing in for the core
module ahb_master (
  input wire logic clk,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hresp
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Held address phase, then held data phase; released lines flip
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    haddr <= ~a;
    hwdata <= wr ? wd : ~hwdata;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    err = hresp;
    hwdata <= ~hwdata;
  endtask
endmodule

// ===== test/flash_bus_checker.sv
`timescale 1ns/10ps
// Bus timing and readout protection checks seen from the pins
module flash_bus_checker
  import flash_ctrl_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic CPU_HALTED,
  input wire logic DEBUG_ACCESS,
  input wire logic RAM_DEBUG_BLOCK
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  logic taken, arr_rd, reg_acc, guard, rd_pend;
  // Transfer decode; lock seen through the RAM block level
  assign taken = HSEL && HTRANS[1] && HREADY;
  assign arr_rd = taken && !HWRITE && !HADDR[REG_SPACE_BIT];
  assign reg_acc = taken && HADDR[REG_SPACE_BIT];
  assign guard = RAM_DEBUG_BLOCK && CPU_HALTED;
  // Locked non-debug read outstanding; error replies may keep old data
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) rd_pend <= 1'b0;
    else if (arr_rd && guard && !DEBUG_ACCESS) rd_pend <= 1'b1;
    else if (HREADYOUT) rd_pend <= 1'b0;
  end
  sequence s_wait2;
    !HREADYOUT ##1 !HREADYOUT;
  endsequence
  sequence s_err;
    (HRESP && !HREADYOUT) ##1 (HRESP && HREADYOUT);
  endsequence
  property p_arr_wait;
    arr_rd && !(DEBUG_ACCESS && guard) |=> s_wait2;
  endproperty
  a_arr_wait: assert property (p_arr_wait) else $error("array read too early");
  property p_arr_okay;
    arr_rd && !(DEBUG_ACCESS && guard) |=> !HRESP [*2];
  endproperty
  a_arr_okay: assert property (p_arr_okay) else $error("array read error");
  property p_reg_fast;
    reg_acc |=> HREADYOUT && !HRESP;
  endproperty
  a_reg_fast: assert property (p_reg_fast) else $error("register wait");
  property p_err_shape;
    arr_rd && DEBUG_ACCESS && guard |=> s_err;
  endproperty
  a_err_shape: assert property (p_err_shape) else $error("no error reply");
  property p_err_cause;
    $rose(HRESP) |-> !HREADYOUT && $past(arr_rd && DEBUG_ACCESS && guard);
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("stray error");
  property p_err_end;
    HRESP && HREADYOUT |=> !HRESP;
  endproperty
  a_err_end: assert property (p_err_end) else $error("error too long");
  property p_locked_zero;
    rd_pend && HREADYOUT |-> HRDATA == 32'h0;
  endproperty
  a_locked_zero: assert property (p_locked_zero) else $error("locked data");
  property p_size;
    reg_acc && !HWRITE && HADDR[7:0] == OFF_SIZE |=> HRDATA == SIZE_VALUE;
  endproperty
  a_size: assert property (p_size) else $error("size word");
endmodule

bind embedded_flash_controller flash_bus_checker i_flash_bus_checker (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .CPU_HALTED(CPU_HALTED), .DEBUG_ACCESS(DEBUG_ACCESS), .RAM_DEBUG_BLOCK(RAM_DEBUG_BLOCK));

// ===== test/tb.sv
`timescale 1ns/10ps
module tb;
  import flash_ctrl_pkg::*;
  localparam logic [31:0] RB = 32'h00040000;
  logic clk, rst_n, hsel, hwrite, hready, hresp, halted, dbg, ram_blk, err;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [31:0] bw [4] = '{32'h11112222, 32'h33334444, ERASED_WORD, 32'h55556666};
  logic [15:0] pi [4] = '{16'h05ff, 16'h0601, 16'h0685, 16'h0686};
  logic [31:0] pe [4] = '{32'h33334444, ERASED_WORD, ERASED_WORD, ERASED_WORD};
  int mismatches, checks_done;
  // Short erase and program times keep the run small
  embedded_flash_controller #(.ERASE_CYCLES(24'h8), .PROG_CYCLES(24'h4), .STEP_CYCLES(24'h2))
    i_embedded_flash_controller (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
    .HRESP(hresp), .CPU_HALTED(halted), .DEBUG_ACCESS(dbg), .RAM_DEBUG_BLOCK(ram_blk));
  ahb_master i_ahb_master (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hresp(hresp));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [31:0] aa(input logic [15:0] i);
    return {14'h0, i, 2'b00};
  endfunction
  // Register write and any read, through the bus master
  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    i_ahb_master.xfer(1'b1, RB | off, d, rd, err);
  endtask
  task automatic rr(input logic [31:0] a);
    i_ahb_master.xfer(1'b0, a, 32'h0, rd, err);
  endtask
  // Poll for finished, then clear every flag
  task automatic finish;
    int n;
    n = 0;
    do begin
      rr(RB | OFF_RAW);
      n++;
    end while (rd[FLAG_DONE] !== 1'b1 && n < 50000);
    chk("finished", 32'h1, {31'h0, rd[FLAG_DONE]});
    wr(OFF_STATUS, 32'h3f);
    rr(RB | OFF_RAW);
    chk("cleared", 32'h0, rd);
  endtask
  task automatic cmd(input logic [31:0] code);
    wr(OFF_COMMAND, code);
    rr(RB | OFF_RAW);
    chk("started", 32'h2, rd & 32'h3);
    finish;
  endtask
  task automatic t_reset;
    rr(RB | OFF_MASK);
    chk("mask", 32'h3f, rd);
    rr(RB | OFF_DATA3);
    chk("data3", DATA_RST, rd);
    rr(RB | OFF_SIZE);
    chk("size", SIZE_VALUE, rd);
    rr(RB | 32'h30);
    chk("hole", 32'h0, rd);
    $display("reset done");
  endtask
  task automatic t_erase;
    cmd(CMD_MASS_ERASE);
    rr(aa(16'hffff));
    chk("last", ERASED_WORD, rd);
    chk("ramblk", 32'h0, {31'h0, ram_blk});
    $display("erase done");
  endtask
  // Second program only clears further bits
  task automatic t_write;
    wr(OFF_ADDRESS, 32'h0685);
    wr(OFF_PROGRAM_DATA_WORD_FIRST, 32'h12345678);
    cmd(CMD_WRITE);
    wr(OFF_PROGRAM_DATA_WORD_FIRST, 32'hffff00ff);
    cmd(CMD_WRITE);
    rr(aa(16'h0685));
    chk("twice", 32'h12340078, rd);
    $display("write done");
  endtask
  // Busy and illegal codes must leave work and array alone
  task automatic t_reject;
    wr(OFF_ADDRESS, 32'h0686);
    wr(OFF_PROGRAM_DATA_WORD_FIRST, 32'h0000aaaa);
    wr(OFF_COMMAND, CMD_WRITE);
    wr(OFF_COMMAND, CMD_MASS_ERASE);
    rr(RB | OFF_RAW);
    chk("busy", 32'h4, rd & 32'h4);
    finish;
    rr(RB | OFF_COMMAND);
    chk("command", CMD_WRITE, rd);
    wr(OFF_COMMAND, 32'h00000155);
    rr(RB | OFF_RAW);
    chk("illegal", 32'h8, rd);
    wr(OFF_STATUS, 32'h3f);
    rr(aa(16'h0686));
    chk("kept", 32'h0000aaaa, rd);
    $display("reject done");
  endtask
  // Burst straddles a page edge, third word all ones
  task automatic t_burst;
    wr(OFF_ADDRESS, 32'h05fe);
    for (int i = 0; i < 4; i++) wr(OFF_PROGRAM_DATA_WORD_FIRST + 8'(4 * i), bw[i]);
    cmd(CMD_BURST);
    for (int i = 0; i < 4; i++) begin
      rr(aa(16'h05fe + 16'(i)));
      chk("burst", bw[i], rd);
    end
    $display("burst done");
  endtask
  task automatic t_page;
    wr(OFF_ADDRESS, 32'h0600);
    cmd(CMD_PAGE_ERASE);
    for (int i = 0; i < 4; i++) begin
      rr(aa(pi[i]));
      chk("page", pe[i], rd);
    end
    $display("page done");
  endtask
  // Verify pass cut short by a reset; the array keeps its words, the signature reseeds
  task automatic t_abort;
    wr(OFF_PROGRAM_DATA_WORD_FIRST, 32'h0);
    wr(OFF_COMMAND, CMD_MASS_READ);
    rr(RB | OFF_RAW);
    chk("verify start", 32'h2, rd);
    wr(OFF_STATUS, 32'h2);
    rr(RB | OFF_RAW);
    chk("start clear", 32'h0, rd);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rr(RB | OFF_SIGNATURE);
    chk("seed", SIG_SEED, rd);
    rr(aa(16'h05ff));
    chk("kept word", 32'h33334444, rd);
    $display("abort done");
  endtask
  // Arm the lock, then try debugger and core reads while halted, and a debugger read while running
  task automatic t_lock;
    halted <= 1'b1;
    dbg <= 1'b1;
    rr(aa(16'h05ff));
    chk("open err", 32'h0, {31'h0, err});
    wr(OFF_PROGRAM_DATA_WORD_FIRST, 32'h0);
    wr(OFF_ADDRESS, 32'hfffe);
    cmd(CMD_WRITE);
    wr(OFF_ADDRESS, 32'hffff);
    cmd(CMD_WRITE);
    chk("ramblk", 32'h1, {31'h0, ram_blk});
    rr(aa(16'h05ff));
    chk("dbg err", 32'h1, {31'h0, err});
    dbg <= 1'b0;
    rr(aa(16'h05ff));
    chk("halt zero", 32'h0, rd);
    halted <= 1'b0;
    dbg <= 1'b1;
    rr(aa(16'h05ff));
    chk("running", 32'h33334444, rd);
    $display("lock done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Whole run is near 70k cycles; a hang is stopped at 90k cycles
  initial begin
    #360000;
    mismatches++;
    results;
  end
  initial begin
    rst_n = 1'b0;
    halted = 1'b0;
    dbg = 1'b0;
    mismatches = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_erase;
    t_write;
    t_reject;
    t_burst;
    t_page;
    t_abort;
    t_lock;
    results;
  end
endmodule
